// ===== core/pte_ctrl.sv
// APB register bank for self-test, 10 Mb test pattern, soft reset and energy detect
`timescale 1ns/1ps
module pte_ctrl
    import pte_pkg::*;
#(
    parameter int IDLE_CYCLES = PTE_IDLE_CYC,
    parameter int SRST_CYCLES = PTE_SRST_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PTE_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic bist_start,
    input wire logic bist_nibble_err,
    input wire logic energy_strap,
    input wire logic ed_data_event,
    input wire logic ed_err_event,
    input wire logic line_energy,
    output logic selftest_continuous,
    output logic pattern_gen_enable,
    output logic pattern_gap_select,
    output logic [1:0] pattern_select,
    output logic pattern_seq_start,
    output logic core_soft_reset,
    output logic ed_power_state,
    output logic ed_power_up_start,
    output logic ed_power_down_start,
    output logic ed_data_pulse
);
    localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);

    if (IDLE_CYCLES < 2 || SRST_CYCLES < 1 || SRST_CYCLES > 255)
    begin : gen_bad_param
        $error("pte_ctrl: timing parameter out of range");
    end

    function automatic logic [3:0] sat_inc4(input logic [3:0] v, input logic inc);
        sat_inc4 = (inc && v != PTE_EVT_MAX) ? v + 4'h1 : v;
    endfunction : sat_inc4

    logic setup_ph;
    logic wr_en;
    logic rd_en;
    logic hit_test;
    logic hit_phy2;
    logic hit_ed;
    logic wr_test;
    logic wr_phy2;
    logic wr_ed;
    logic rd_ed;
    logic [31:0] next_prdata;
    logic [7:0] err_nib;
    logic [2:0] rsv_bits;
    logic [7:0] srst_cnt;
    logic [7:0] next_srst_cnt;
    logic strap_taken;
    logic energy_mgmt_enable;
    logic auto_power_up;
    logic auto_power_down;
    logic manual_power_toggle;
    logic pulse_burst_disable;
    logic [3:0] energy_data_threshold;
    logic [3:0] energy_error_threshold;
    logic [3:0] data_cnt;
    logic [3:0] err_cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic idle_expire;
    logic data_hit;
    logic err_hit;
    logic data_met;
    logic err_met;
    pte_ed_state_type ed_state;
    pte_ed_state_type next_ed_state;
    logic man_clear;
    logic [2:0] pulse_cnt;
    logic [3:0] space_cnt;
    logic [2:0] burst_target;
    logic burst_done;

    // APB decode; zero-wait answer one cycle after setup
    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && pready && !pwrite;
    assign hit_test = pte_hit(paddr, PTE_IDX_TEST);
    assign hit_phy2 = pte_hit(paddr, PTE_IDX_PHY2);
    assign hit_ed = pte_hit(paddr, PTE_IDX_ED);
    assign wr_test = wr_en && hit_test;
    assign wr_phy2 = wr_en && hit_phy2;
    assign wr_ed = wr_en && hit_ed;
    assign rd_ed = rd_en && hit_ed;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= setup_ph;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= setup_ph && !(hit_test || hit_phy2 || hit_ed);
    end

    always_comb
    begin
        next_prdata = 32'h0;
        if (hit_test)
        begin
            next_prdata[PTE_CNT_LSB +: 8] = err_nib;
            next_prdata[PTE_RSV_HI_LSB +: 2] = rsv_bits[2:1];
            next_prdata[PTE_CONT_BIT] = selftest_continuous;
            next_prdata[PTE_PEN_BIT] = pattern_gen_enable;
            next_prdata[PTE_RSV_LO_BIT] = rsv_bits[0];
            next_prdata[PTE_GAP_BIT] = pattern_gap_select;
            next_prdata[PTE_SEL_LSB +: 2] = pattern_select;
        end
        else if (hit_phy2)
        begin
            // Only the busy soft reset shows; all else zero
            next_prdata[PTE_SRST_BIT] = core_soft_reset;
        end
        else if (hit_ed)
        begin
            next_prdata[PTE_ENERGY_MGMT_ENABLE_BIT] = energy_mgmt_enable;
            next_prdata[PTE_ED_UP_BIT] = auto_power_up;
            next_prdata[PTE_ED_DN_BIT] = auto_power_down;
            next_prdata[PTE_MANUAL_POWER_TOGGLE_BIT] = manual_power_toggle;
            next_prdata[PTE_ED_BD_BIT] = pulse_burst_disable;
            next_prdata[PTE_ED_PWR_BIT] = ed_power_state;
            next_prdata[PTE_ED_EMET_BIT] = err_met;
            next_prdata[PTE_ED_DMET_BIT] = data_met;
            next_prdata[PTE_ED_ETHR_LSB +: 4] = energy_error_threshold;
            next_prdata[PTE_ED_DTHR_LSB +: 4] = energy_data_threshold;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup_ph && !pwrite)
            prdata <= next_prdata;
    end

    // Test pattern and self-test configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            selftest_continuous <= 1'b0;
            pattern_gen_enable <= 1'b0;
            pattern_gap_select <= 1'b0;
            pattern_select <= 2'h0;
            rsv_bits <= 3'h0;
        end
        else if (wr_test)
        begin
            selftest_continuous <= pwdata[PTE_CONT_BIT];
            pattern_gen_enable <= pwdata[PTE_PEN_BIT];
            pattern_gap_select <= pwdata[PTE_GAP_BIT];
            pattern_select <= pwdata[PTE_SEL_LSB +: 2];
            // Stored as written; software keeps them zero
            rsv_bits <= {pwdata[PTE_RSV_HI_LSB +: 2], pwdata[PTE_RSV_LO_BIT]};
        end
    end

    // Error nibble count; a restart beats a same-cycle error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_nib <= 8'h0;
        else if (bist_start)
            err_nib <= 8'h0;
        else if (bist_nibble_err && err_nib != PTE_CNT_MAX)
            err_nib <= err_nib + 8'h01;
    end

    pte_gap_timer u_gap (
        .pclk(pclk),
        .presetn(presetn),
        .clear(core_soft_reset),
        .enable(pattern_gen_enable),
        .gap_long(pattern_gap_select),
        .seq_start(pattern_seq_start)
    );

    // Soft reset: a write of one restarts the run, zero is ignored
    always_comb
    begin
        next_srst_cnt = srst_cnt;
        if (wr_phy2 && pwdata[PTE_SRST_BIT])
            next_srst_cnt = 8'(SRST_CYCLES);
        else if (srst_cnt != 8'h0)
            next_srst_cnt = srst_cnt - 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            srst_cnt <= 8'h0;
            core_soft_reset <= 1'b0;
        end
        else
        begin
            srst_cnt <= next_srst_cnt;
            core_soft_reset <= next_srst_cnt != 8'h0;
        end
    end

    // Strap taken on the first edge after release, not under reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_taken <= 1'b0;
            energy_mgmt_enable <= 1'b0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            energy_mgmt_enable <= energy_strap;
        end
        else if (wr_ed)
            energy_mgmt_enable <= pwdata[PTE_ENERGY_MGMT_ENABLE_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            auto_power_up <= PTE_AUTO_UP_RST;
            auto_power_down <= PTE_AUTO_DN_RST;
            pulse_burst_disable <= 1'b0;
            energy_error_threshold <= PTE_THR_RST;
            energy_data_threshold <= PTE_THR_RST;
        end
        else if (wr_ed)
        begin
            auto_power_up <= pwdata[PTE_ED_UP_BIT];
            auto_power_down <= pwdata[PTE_ED_DN_BIT];
            pulse_burst_disable <= pwdata[PTE_ED_BD_BIT];
            energy_error_threshold <= pwdata[PTE_ED_ETHR_LSB +: 4];
            energy_data_threshold <= pwdata[PTE_ED_DTHR_LSB +: 4];
        end
    end

    // A new write of one wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            manual_power_toggle <= 1'b0;
        else if (wr_ed && pwdata[PTE_MANUAL_POWER_TOGGLE_BIT])
            manual_power_toggle <= 1'b1;
        else if (man_clear)
            manual_power_toggle <= 1'b0;
    end

    // Event counting with idle clear
    assign idle_expire = idle_cnt == IDLE_W'(IDLE_CYCLES - 1);
    assign data_hit = data_cnt >= energy_data_threshold;
    assign err_hit = err_cnt >= energy_error_threshold;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_cnt <= '0;
        else if (core_soft_reset || ed_data_event || idle_expire)
            idle_cnt <= '0;
        else
            idle_cnt <= idle_cnt + IDLE_W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_cnt <= 4'h0;
            err_cnt <= 4'h0;
        end
        else if (core_soft_reset || idle_expire || ed_power_up_start)
        begin
            data_cnt <= 4'h0;
            err_cnt <= 4'h0;
        end
        else
        begin
            data_cnt <= sat_inc4(data_cnt, ed_data_event);
            err_cnt <= sat_inc4(err_cnt, ed_err_event);
        end
    end

    // Informational flags, cleared by a read; a new hit wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_met <= 1'b0;
            err_met <= 1'b0;
        end
        else
        begin
            data_met <= (data_hit && data_cnt != 4'h0) || (data_met && !rd_ed);
            err_met <= (err_hit && err_cnt != 4'h0) || (err_met && !rd_ed);
        end
    end

    // Power manager; parked powered up while disabled
    always_comb
    begin
        next_ed_state = ed_state;
        case (ed_state)
            PTE_ED_DOWN:
                if (manual_power_toggle)
                    next_ed_state = PTE_ED_RISING;
                else if (auto_power_up && data_hit)
                    next_ed_state = PTE_ED_RISING;
            PTE_ED_RISING:
                if (burst_done)
                    next_ed_state = PTE_ED_UP;
            PTE_ED_UP:
                if (manual_power_toggle)
                    next_ed_state = PTE_ED_FALLING;
                else if (auto_power_down && !line_energy)
                    next_ed_state = PTE_ED_FALLING;
            PTE_ED_FALLING:
                next_ed_state = PTE_ED_DOWN;
            default:
                next_ed_state = PTE_ED_UP;
        endcase
        if (!energy_mgmt_enable || core_soft_reset)
            next_ed_state = PTE_ED_UP;
    end

    assign man_clear = manual_power_toggle && (!energy_mgmt_enable || core_soft_reset
        || ed_state == PTE_ED_DOWN || ed_state == PTE_ED_UP);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ed_state <= PTE_ED_UP;
        else
            ed_state <= next_ed_state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ed_power_state <= 1'b1;
            ed_power_up_start <= 1'b0;
            ed_power_down_start <= 1'b0;
        end
        else
        begin
            ed_power_state <= next_ed_state == PTE_ED_UP || next_ed_state == PTE_ED_RISING;
            ed_power_up_start <= ed_state == PTE_ED_DOWN && next_ed_state == PTE_ED_RISING;
            ed_power_down_start <= ed_state == PTE_ED_UP && next_ed_state == PTE_ED_FALLING;
        end
    end

    // Pulse burst while rising; last pulse is followed by one full space
    assign burst_target = pulse_burst_disable ? PTE_BURST_ONE : PTE_BURST_LEN;
    assign burst_done = pulse_cnt == burst_target && space_cnt == 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_cnt <= 3'h0;
            space_cnt <= 4'h0;
        end
        else if (ed_state != PTE_ED_RISING || core_soft_reset)
        begin
            pulse_cnt <= 3'h0;
            space_cnt <= 4'h0;
        end
        else
        begin
            space_cnt <= (space_cnt == PTE_SPACE_LAST) ? 4'h0 : space_cnt + 4'h1;
            if (space_cnt == 4'h0 && pulse_cnt != burst_target)
                pulse_cnt <= pulse_cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ed_data_pulse <= 1'b0;
        else
            ed_data_pulse <= ed_state == PTE_ED_RISING && !core_soft_reset
                && space_cnt == 4'h0 && pulse_cnt != burst_target;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    nib_count_a: assert property (
        bist_nibble_err && !bist_start && err_nib != PTE_CNT_MAX |=> err_nib == $past(err_nib) + 8'h01)
        else $error("nibble count did not advance");
    nib_restart_a: assert property (
        bist_start |=> err_nib == 8'h0)
        else $error("nibble count not cleared on restart");
    nib_sat_a: assert property (
        err_nib == PTE_CNT_MAX && !bist_start |=> err_nib == PTE_CNT_MAX)
        else $error("nibble count wrapped");
    pat_off_a: assert property (
        !pattern_gen_enable && !$past(pattern_gen_enable) |-> !pattern_seq_start)
        else $error("pattern started while disabled");
    srst_keep_a: assert property (
        core_soft_reset && !wr_test |=> $stable(pattern_select) && $stable(selftest_continuous))
        else $error("soft reset disturbed configuration");
    srst_end_a: assert property (
        wr_phy2 && pwdata[PTE_SRST_BIT] |=> core_soft_reset ##[1:255] !core_soft_reset)
        else $error("soft reset did not self-clear");
    phy2_zero_a: assert property (
        setup_ph && !pwrite && hit_phy2 |=> (prdata & ~PTE_PHY2_MASK) == 32'h0)
        else $error("second control reserved bits not zero");
    auto_up_a: assert property (
        ed_state == PTE_ED_DOWN && auto_power_up && data_hit && energy_mgmt_enable
        && !core_soft_reset |=> ed_state == PTE_ED_RISING && ed_power_up_start)
        else $error("auto power-up missed");
    auto_down_a: assert property (
        ed_state == PTE_ED_UP && auto_power_down && !line_energy && energy_mgmt_enable
        && !core_soft_reset |=> ed_state == PTE_ED_FALLING ##1 ed_state == PTE_ED_DOWN)
        else $error("auto power-down missed");
    man_clear_a: assert property (
        manual_power_toggle && ed_state == PTE_ED_UP && !(wr_ed && pwdata[PTE_MANUAL_POWER_TOGGLE_BIT])
        && energy_mgmt_enable && !core_soft_reset
        |=> !manual_power_toggle && ed_state != PTE_ED_UP)
        else $error("manual toggle not taken");
    burst_len_a: assert property (
        ed_state == PTE_ED_RISING && next_ed_state == PTE_ED_UP && energy_mgmt_enable
        && !core_soft_reset |-> pulse_cnt == burst_target && pulse_cnt != 3'h0)
        else $error("power-up burst length wrong");

    nib_sat_c: cover property (err_nib == PTE_CNT_MAX && bist_nibble_err);
    srst_c: cover property ($fell(core_soft_reset));
    power_up_c: cover property (ed_power_up_start ##[1:100] ed_state == PTE_ED_UP);
    power_down_c: cover property (ed_power_down_start);
endmodule : pte_ctrl

// ===== core/pte_pkg.sv
// Offsets, field positions, reset values and timings of the test and energy control block
//
// Operation
// - Count errored nibbles during self-test
// - Self-test restart clears error nibble count
// - Error nibble count saturates at maximum
// - Continuous bit gives gapless pseudo-random transmission
// - Pattern enable bit, reset off
// - Gap select: 15 us or 10 us
// - Two-bit select picks the test pattern
// - Soft reset spares management registers
// - Soft reset bit clears itself when done
// - Other second-control bits read zero
// - Energy enable resets from strap, writable
// - Auto power-up at data threshold
// - Auto power-down when no line energy
// - Manual bit toggles power state immediately
// - Thresholds reset to one; counters idle-clear
// - Power-up sends burst of four pulses
package pte_pkg;
    localparam int PTE_CLK_MHZ = 50;
    localparam int PTE_ADDR_W = 10;
    localparam logic [7:0] PTE_IDX_TEST = 8'h1b;
    localparam logic [7:0] PTE_IDX_PHY2 = 8'h1c;
    localparam logic [7:0] PTE_IDX_ED = 8'h1d;
    localparam int PTE_CNT_LSB = 8;
    localparam logic [7:0] PTE_CNT_MAX = 8'hff;
    localparam int PTE_RSV_HI_LSB = 6;
    localparam int PTE_CONT_BIT = 5;
    localparam int PTE_PEN_BIT = 4;
    localparam int PTE_RSV_LO_BIT = 3;
    localparam int PTE_GAP_BIT = 2;
    localparam int PTE_SEL_LSB = 0;
    localparam int PTE_SRST_BIT = 9;
    localparam logic [31:0] PTE_PHY2_MASK = 32'h0000_0200;
    localparam int PTE_ENERGY_MGMT_ENABLE_BIT = 15;
    localparam int PTE_ED_UP_BIT = 14;
    localparam int PTE_ED_DN_BIT = 13;
    localparam int PTE_MANUAL_POWER_TOGGLE_BIT = 12;
    localparam int PTE_ED_BD_BIT = 11;
    localparam int PTE_ED_PWR_BIT = 10;
    localparam int PTE_ED_EMET_BIT = 9;
    localparam int PTE_ED_DMET_BIT = 8;
    localparam int PTE_ED_ETHR_LSB = 4;
    localparam int PTE_ED_DTHR_LSB = 0;
    localparam logic PTE_AUTO_UP_RST = 1'b1;
    localparam logic PTE_AUTO_DN_RST = 1'b1;
    localparam logic [3:0] PTE_THR_RST = 4'h1;
    localparam logic [3:0] PTE_EVT_MAX = 4'hf;
    localparam int PTE_GAP_SHORT_US = 10;
    localparam int PTE_GAP_LONG_US = 15;
    localparam int PTE_GAP_SHORT_CYC = PTE_GAP_SHORT_US * PTE_CLK_MHZ;
    localparam int PTE_GAP_LONG_CYC = PTE_GAP_LONG_US * PTE_CLK_MHZ;
    localparam int PTE_IDLE_MS = 2000;
    localparam int PTE_IDLE_CYC = PTE_IDLE_MS * 1000 * PTE_CLK_MHZ;
    localparam int PTE_SRST_CYC = 4;
    localparam logic [2:0] PTE_BURST_LEN = 3'h4;
    localparam logic [2:0] PTE_BURST_ONE = 3'h1;
    localparam logic [3:0] PTE_SPACE_LAST = 4'h7;

    typedef enum logic [1:0] {
        PTE_ED_DOWN = 2'b00,
        PTE_ED_RISING = 2'b01,
        PTE_ED_UP = 2'b11,
        PTE_ED_FALLING = 2'b10
    } pte_ed_state_type;

    function automatic logic pte_hit(input logic [PTE_ADDR_W-1:0] addr, input logic [7:0] idx);
        pte_hit = (addr == {idx, 2'b00});
    endfunction : pte_hit
endpackage : pte_pkg

// ===== core/pte_gap_timer.sv
// Spacing timer for 10 Mb test pattern sequences
`timescale 1ns/1ps
module pte_gap_timer
    import pte_pkg::*;
#(
    parameter int SHORT_CYC = PTE_GAP_SHORT_CYC,
    parameter int LONG_CYC = PTE_GAP_LONG_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic enable,
    input wire logic gap_long,
    output logic seq_start
);
    localparam int W = $clog2(LONG_CYC + 1);

    if (SHORT_CYC < 2 || LONG_CYC <= SHORT_CYC)
    begin : gen_bad_gap
        $error("pte_gap_timer: gap lengths unusable");
    end

    logic [W-1:0] cnt;
    logic [W-1:0] last;

    // Select may change mid-gap, hence >= rather than ==
    assign last = gap_long ? W'(LONG_CYC - 1) : W'(SHORT_CYC - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt <= '0;
        else if (clear || !enable || cnt >= last)
            cnt <= '0;
        else
            cnt <= cnt + W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seq_start <= 1'b0;
        else
            seq_start <= enable && !clear && cnt == '0;
    end
endmodule : pte_gap_timer

// ===== verif/tb_phy_test_energy_ctrl.sv
// Self-checking bench for the test pattern, soft reset and energy control registers
`timescale 1ns/1ps
module tb_phy_test_energy_ctrl
    import pte_pkg::*;
;
    localparam logic [9:0] A_TEST = {PTE_IDX_TEST, 2'b00};
    localparam logic [9:0] A_PHY2 = {PTE_IDX_PHY2, 2'b00};
    localparam logic [9:0] A_ED = {PTE_IDX_ED, 2'b00};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bist_start = 0;
    logic bist_nibble_err = 0, energy_strap = 1, ed_data_event = 0, ed_err_event = 0;
    logic line_energy = 1, pready, pslverr, selftest_continuous, pattern_gen_enable;
    logic pattern_gap_select, pattern_seq_start, core_soft_reset, ed_power_state;
    logic ed_power_up_start, ed_power_down_start, ed_data_pulse, er;
    logic [1:0] pattern_select;
    logic [9:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    int errors = 0, samples_checked = 0, p, c, u, dn, q;

    // Short idle timeout keeps the event counter clearing inside the run
    pte_ctrl #(.IDLE_CYCLES(50), .SRST_CYCLES(4)) dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .bist_start, .bist_nibble_err,
        .energy_strap, .ed_data_event, .ed_err_event, .line_energy, .selftest_continuous,
        .pattern_gen_enable, .pattern_gap_select, .pattern_select, .pattern_seq_start,
        .core_soft_reset, .ed_power_state, .ed_power_up_start, .ed_power_down_start,
        .ed_data_pulse);

    always #10 pclk = ~pclk;

    task tick(input int k);
        repeat (k) @(posedge pclk);
    endtask : tick

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count assumed; only the watchdog ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Period between sequence starts; the first one seen may be cut short
    task gap;
        p = 0;
        while (pattern_seq_start !== 1'b1 && p < 2000)
        begin
            @(posedge pclk);
            p++;
        end
        p = 0;
        do
        begin
            @(posedge pclk);
            p++;
        end
        while (pattern_seq_start !== 1'b1 && p < 2000);
    endtask : gap

    task pulses(input int k);
        c = 0;
        u = 0;
        dn = 0;
        q = 0;
        repeat (k)
        begin
            @(posedge pclk);
            c += (ed_data_pulse === 1'b1);
            u += (ed_power_up_start === 1'b1);
            dn += (ed_power_down_start === 1'b1);
            q += (pattern_seq_start === 1'b1);
        end
    endtask : pulses

    task t_reset;
        apb(0, A_TEST, 0);
        chk("test_reg", 32'h0, rd);
        apb(0, A_PHY2, 0);
        chk("phy2_reg", 32'h0, rd);
        apb(0, A_ED, 0);
        chk("energy_reg", 32'h0000_e411, rd);
        apb(0, 10'h078, 0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        $display("test reset done");
    endtask : t_reset

    task t_nibble;
        @(posedge pclk);
        bist_start <= 1'b1;
        @(posedge pclk);
        bist_start <= 1'b0;
        bist_nibble_err <= 1'b1;
        tick(3);
        bist_nibble_err <= 1'b0;
        apb(0, A_TEST, 0);
        chk("nibble_cnt", 32'h3, {24'h0, rd[15:8]});
        bist_nibble_err <= 1'b1;
        tick(300);
        bist_nibble_err <= 1'b0;
        apb(0, A_TEST, 0);
        chk("nibble_cnt", 32'hff, {24'h0, rd[15:8]});
        bist_start <= 1'b1;
        tick(1);
        bist_start <= 1'b0;
        apb(0, A_TEST, 0);
        chk("nibble_cnt", 32'h0, {24'h0, rd[15:8]});
        $display("test nibble done");
    endtask : t_nibble

    task t_pattern;
        // Long-transmit guard taken as already off upstream
        for (int s = 0; s < 4; s++)
        begin
            apb(1, A_TEST, 32'h30 | s);
            tick(2);
            chk("select", s, {30'h0, pattern_select});
            chk("enable_cont", 32'h3, {30'h0, pattern_gen_enable, selftest_continuous});
        end
        apb(1, A_TEST, 32'h14);
        gap;
        chk("gap_long", PTE_GAP_LONG_CYC, p);
        chk("gap_bit", 32'h1, {31'h0, pattern_gap_select});
        apb(1, A_TEST, 32'h10);
        gap;
        gap;
        chk("gap_short", PTE_GAP_SHORT_CYC, p);
        chk("gap_bit", 32'h0, {31'h0, pattern_gap_select});
        $display("test pattern done");
    endtask : t_pattern

    task t_soft;
        apb(1, A_PHY2, 32'h200);
        tick(2);
        chk("soft_reset", 32'h1, {31'h0, core_soft_reset});
        tick(8);
        apb(0, A_PHY2, 0);
        chk("phy2_reg", 32'h0, rd);
        apb(0, A_TEST, 0);
        chk("test_kept", 32'h10, rd);
        apb(1, A_PHY2, 32'hfdff);
        tick(2);
        chk("soft_reset", 32'h0, {31'h0, core_soft_reset});
        apb(0, A_PHY2, 0);
        chk("phy2_reg", 32'h0, rd);
        $display("test soft reset done");
    endtask : t_soft

    task t_energy;
        line_energy <= 1'b0;
        pulses(6);
        chk("power_state", 32'h0, {31'h0, ed_power_state});
        chk("down_start", 32'h1, dn);
        line_energy <= 1'b1;
        ed_data_event <= 1'b1;
        tick(1);
        ed_data_event <= 1'b0;
        pulses(60);
        chk("burst", 32'h4, c);
        chk("up_start", 32'h1, u);
        // Auto-negotiation stays on here, so crossover may stay on
        apb(1, A_ED, 32'hf011);
        pulses(6);
        chk("power_state", 32'h0, {31'h0, ed_power_state});
        chk("down_start", 32'h1, dn);
        apb(0, A_ED, 0);
        chk("manual_bit", 32'h0, {31'h0, rd[12]});
        apb(1, A_ED, 32'hf811);
        pulses(30);
        chk("single", 32'h1, c);
        chk("up_start", 32'h1, u);
        chk("power_state", 32'h1, {31'h0, ed_power_state});
        apb(1, A_ED, 32'h6011);
        apb(0, A_ED, 0);
        chk("ed_enable", 32'h0, {31'h0, rd[15]});
        apb(1, A_TEST, 32'h0);
        // One edge lets a start launched on the write edge drain
        tick(1);
        pulses(600);
        chk("seq_off", 32'h0, q);
        $display("test energy done");
    endtask : t_energy

    task results;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    initial
    begin
        tick(16);
        presetn <= 1'b1;
        t_reset;
        t_nibble;
        t_pattern;
        t_soft;
        t_energy;
        results;
    end

    initial
    begin
        tick(20000);
        errors++;
        results;
    end
endmodule : tb_phy_test_energy_ctrl
